// ===== rtl/ocd_pkg.sv
// constants for the two output-channel clock dividers
package ocd_pkg;
	// printed offsets are register indices; byte address is four times the index
	localparam logic [9:0] IDX_CNT0 = 10'h190;
	localparam logic [9:0] IDX_CTL0 = 10'h191;
	localparam logic [9:0] IDX_RTE0 = 10'h192;
	localparam logic [9:0] IDX_CNT1 = 10'h193;
	localparam logic [9:0] IDX_CTL1 = 10'h194;
	localparam logic [9:0] IDX_RTE1 = 10'h195;
	localparam logic [9:0] IDX_SRC = 10'h1E1;
	localparam logic [9:0] IDX_STAT = 10'h1FF;
	localparam int LOW_HI = 7;
	localparam int LOW_LO = 4;
	localparam int HIGH_HI = 3;
	localparam int HIGH_LO = 0;
	localparam int BIT_BYPASS = 7;
	localparam int BIT_NOSYNC = 6;
	localparam int BIT_FORCE = 5;
	localparam int BIT_START = 4;
	localparam int PH_HI = 3;
	localparam int PH_LO = 0;
	localparam int BIT_DIRECT = 1;
	localparam int BIT_DUTY_CORRECTION_DISABLE = 0;
	localparam logic [7:0] RTE_MASK = 8'h03;
	localparam logic [7:0] SRC_MASK = 8'h03;
	localparam logic [1:0] SRC_OSC = 2'b10;
	localparam logic [1:0] SRC_EXT = 2'b00;
	localparam logic [7:0] RST_CNT0 = 8'h00;
	localparam logic [7:0] RST_CTL0 = 8'h80;
	localparam logic [7:0] RST_RTE0 = 8'h00;
	localparam logic [7:0] RST_CNT1 = 8'hBB;
	localparam logic [7:0] RST_CTL1 = 8'h00;
	localparam logic [7:0] RST_RTE1 = 8'h00;
	localparam logic [7:0] RST_SRC = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum {MAP_CNT0, MAP_CTL0, MAP_RTE0, MAP_CNT1, MAP_CTL1, MAP_RTE1,
		MAP_SRC, MAP_STAT, MAP_NONE} ocd_map_type;
endpackage : ocd_pkg

// ===== rtl/ocd_dividers.sv
// two output-channel clock dividers with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module ocd_dividers
	import ocd_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic sync_n_i,
	input wire logic osc_i,
	input wire logic ext_clk_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic pair_a_output_first_o,
	output logic pair_a_output_second_o,
	output logic pair_b_output_first_o,
	output logic pair_b_output_second_o,
	output logic [1:0] duty_correction_enable_o
);

	function automatic ocd_map_type map_addr(input logic [ADDR_W-1:0] a);
		logic [9:0] idx;
		idx = a[11:2];
		case (idx)
			IDX_CNT0: map_addr = MAP_CNT0;
			IDX_CTL0: map_addr = MAP_CTL0;
			IDX_RTE0: map_addr = MAP_RTE0;
			IDX_CNT1: map_addr = MAP_CNT1;
			IDX_CTL1: map_addr = MAP_CTL1;
			IDX_RTE1: map_addr = MAP_RTE1;
			IDX_SRC: map_addr = MAP_SRC;
			IDX_STAT: map_addr = MAP_STAT;
			default: map_addr = MAP_NONE;
		endcase
	endfunction : map_addr

	logic [7:0] cnt_reg [2];
	logic [7:0] ctl_reg [2];
	logic [7:0] rte_reg [2];
	logic [7:0] src_reg;
	logic [ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic aw_got;
	logic w_got;
	logic [2:0] sync_ff;
	logic [2:0] osc_ff;
	logic [2:0] ext_ff;
	logic sync_act;
	logic osc_s;
	logic ext_s;
	logic lvl [2];
	logic [3:0] cnt [2];
	logic [3:0] ph [2];
	logic [1:0] run;
	logic [1:0] hold;
	logic [1:0] sel;
	ocd_map_type wmap;

	assign wmap = map_addr(aw_addr);

	// pins pass three flops; a change counts once the last two agree
	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			sync_ff <= 3'b111;
			osc_ff <= 3'b000;
			ext_ff <= 3'b000;
			sync_act <= 1'b0;
			osc_s <= 1'b0;
			ext_s <= 1'b0;
		end
		else
		begin
			sync_ff <= {sync_ff[1:0], sync_n_i};
			osc_ff <= {osc_ff[1:0], osc_i};
			ext_ff <= {ext_ff[1:0], ext_clk_i};
			if (sync_ff[1] == sync_ff[2])
				sync_act <= ~sync_ff[2];
			if (osc_ff[1] == osc_ff[2])
				osc_s <= osc_ff[2];
			if (ext_ff[1] == ext_ff[2])
				ext_s <= ext_ff[2];
		end

	// write channel: address and data taken in either order, response after both
	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= '0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got <= 1'b1;
				w_byte <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
				s_axi_wready <= 1'b0;
			end
			if (aw_got && w_got && !s_axi_bvalid)
			begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wmap == MAP_NONE) ? RESP_SLVERR : RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
			begin
				// readies stay low from their own transfer until the response is taken
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end

	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			cnt_reg[0] <= RST_CNT0;
			ctl_reg[0] <= RST_CTL0;
			rte_reg[0] <= RST_RTE0;
			cnt_reg[1] <= RST_CNT1;
			ctl_reg[1] <= RST_CTL1;
			rte_reg[1] <= RST_RTE1;
			src_reg <= RST_SRC;
		end
		else if (aw_got && w_got && !s_axi_bvalid && w_lane0)
			case (wmap)
				MAP_CNT0: cnt_reg[0] <= w_byte;
				MAP_CTL0: ctl_reg[0] <= w_byte;
				MAP_RTE0: rte_reg[0] <= w_byte & RTE_MASK;
				MAP_CNT1: cnt_reg[1] <= w_byte;
				MAP_CTL1: ctl_reg[1] <= w_byte;
				MAP_RTE1: rte_reg[1] <= w_byte & RTE_MASK;
				MAP_SRC: src_reg <= w_byte & SRC_MASK;
				default: ;
			endcase

	// read channel; unmapped reads answer zero with an error response
	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_arready <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_arready <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			case (map_addr(s_axi_araddr))
				MAP_CNT0: s_axi_rdata <= {24'h00_0000, cnt_reg[0]};
				MAP_CTL0: s_axi_rdata <= {24'h00_0000, ctl_reg[0]};
				MAP_RTE0: s_axi_rdata <= {24'h00_0000, rte_reg[0]};
				MAP_CNT1: s_axi_rdata <= {24'h00_0000, cnt_reg[1]};
				MAP_CTL1: s_axi_rdata <= {24'h00_0000, ctl_reg[1]};
				MAP_RTE1: s_axi_rdata <= {24'h00_0000, rte_reg[1]};
				MAP_SRC: s_axi_rdata <= {24'h00_0000, src_reg};
				MAP_STAT: s_axi_rdata <= {25'h000_0000, sync_act, run, hold, lvl[1], lvl[0]};
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end

	for (genvar i = 0; i < 2; i++)
	begin : g_div
		logic byp;
		logic nos;
		assign byp = ctl_reg[i][BIT_BYPASS];
		assign nos = ctl_reg[i][BIT_NOSYNC];
		assign hold[i] = sync_act && !nos && !byp;
		assign run[i] = !byp && !nos && !hold[i] && (ph[i] == 4'h0);

		always_ff @(posedge clk_i or posedge sys_rst_i)
			if (sys_rst_i)
			begin
				lvl[i] <= 1'b0;
				cnt[i] <= 4'h0;
				ph[i] <= 4'h0;
			end
			else if (byp)
			begin
				// one input cycle per level stands for the undivided clock
				lvl[i] <= ~lvl[i];
				cnt[i] <= 4'h0;
				ph[i] <= 4'h0;
			end
			else if (nos)
				lvl[i] <= ctl_reg[i][BIT_FORCE];
			else if (hold[i])
			begin
				lvl[i] <= ctl_reg[i][BIT_START];
				ph[i] <= ctl_reg[i][PH_HI:PH_LO];
				cnt[i] <= ctl_reg[i][BIT_START] ? cnt_reg[i][HIGH_HI:HIGH_LO] : cnt_reg[i][LOW_HI:LOW_LO];
			end
			else if (ph[i] != 4'h0)
				ph[i] <= ph[i] - 4'h1;
			else if (cnt[i] == 4'h0)
			begin
				lvl[i] <= ~lvl[i];
				cnt[i] <= lvl[i] ? cnt_reg[i][LOW_HI:LOW_LO] : cnt_reg[i][HIGH_HI:HIGH_LO];
			end
			else
				cnt[i] <= cnt[i] - 4'h1;

		// pair routing: divider, oscillator or clock input
		always_comb
		begin
			sel[i] = lvl[i];
			if (rte_reg[i][BIT_DIRECT] && src_reg[1:0] == SRC_OSC)
				sel[i] = osc_s;
			else if (rte_reg[i][BIT_DIRECT] && src_reg[1:0] == SRC_EXT)
				sel[i] = ext_s;
		end

		AST_LOW_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			$past(run[i]) && run[i] && $fell(lvl[i]) |-> cnt[i] == $past(cnt_reg[i][LOW_HI:LOW_LO]))
			else $error("low count not loaded");
		AST_HIGH_LOAD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			$past(run[i]) && run[i] && $rose(lvl[i]) |-> cnt[i] == $past(cnt_reg[i][HIGH_HI:HIGH_LO]))
			else $error("high count not loaded");
		AST_LEVEL_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			run[i] && cnt[i] != 4'h0 ##1 run[i] |-> $stable(lvl[i]))
			else $error("level moved before count expired");
		AST_BYPASS_TOGGLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			byp ##1 byp |-> lvl[i] != $past(lvl[i]))
			else $error("bypass does not pass the clock");
		AST_SYNC_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			hold[i] ##1 hold[i] |-> lvl[i] == $past(ctl_reg[i][BIT_START]))
			else $error("held divider not at start level");
		AST_FORCE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			nos && !byp ##1 nos && !byp && $stable(ctl_reg[i]) |-> lvl[i] == ctl_reg[i][BIT_FORCE])
			else $error("forced level not applied");
		AST_PHASE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
			$fell(hold[i]) && !byp && !nos |-> ph[i] == $past(ctl_reg[i][PH_HI:PH_LO])
			##1 ($stable(lvl[i]) || $past(ph[i] == 4'h0 && cnt[i] == 4'h0)))
			else $error("phase offset not applied");
		COV_WRAP: cover property (@(posedge clk_i) disable iff (sys_rst_i) run[i] ##1 $rose(lvl[i]));
		COV_HOLD: cover property (@(posedge clk_i) disable iff (sys_rst_i) $fell(hold[i]));
	end

	always_ff @(posedge clk_i or posedge sys_rst_i)
		if (sys_rst_i)
		begin
			pair_a_output_first_o <= 1'b0;
			pair_a_output_second_o <= 1'b1;
			pair_b_output_first_o <= 1'b0;
			pair_b_output_second_o <= 1'b1;
			duty_correction_enable_o <= 2'b11;
		end
		else
		begin
			pair_a_output_first_o <= sel[0];
			pair_a_output_second_o <= ~sel[0];
			pair_b_output_first_o <= sel[1];
			pair_b_output_second_o <= ~sel[1];
			// correction trims sub-cycle edges, so only its enable leaves the block
			duty_correction_enable_o <= {~rte_reg[1][BIT_DUTY_CORRECTION_DISABLE], ~rte_reg[0][BIT_DUTY_CORRECTION_DISABLE]};
		end

	AST_DIFF_PAIR: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		pair_a_output_first_o != pair_a_output_second_o && pair_b_output_first_o != pair_b_output_second_o)
		else $error("pair outputs not complementary");
	AST_DIRECT_OSC: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		rte_reg[0][BIT_DIRECT] && src_reg[1:0] == SRC_OSC |=> pair_a_output_first_o == $past(osc_s))
		else $error("oscillator not routed to pair a");
	AST_NO_EFFECT: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		src_reg[1:0] == 2'b01 |=> pair_b_output_first_o == $past(lvl[1]))
		else $error("source 01b changed routing");
	COV_DIRECT: cover property (@(posedge clk_i) disable iff (sys_rst_i) rte_reg[1][BIT_DIRECT] && src_reg[1:0] == SRC_EXT);

endmodule : ocd_dividers
`default_nettype wire

// ===== tb/ocd_dividers_tb.sv
// self-checking bench for the two output-channel clock dividers
`timescale 1ns/1ps
`default_nettype none
module ocd_dividers_tb
	import ocd_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sync_n_i = 1'b1;
	logic osc_i = 1'b0;
	logic ext_clk_i = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, duty_correction_enable_o;
	logic [31:0] s_axi_rdata;
	logic pa1, pa2, pb1, pb2;
	int miscompares = 0;
	int compares = 0;
	int seed = 32'hc5c830d5;
	int hi, lo, t0, tp, p, k;
	logic [7:0] d;
	logic [9:0] ridx [7] = '{IDX_CNT0, IDX_CTL0, IDX_RTE0, IDX_CNT1, IDX_CTL1, IDX_RTE1, IDX_SRC};
	logic [7:0] rval [7] = '{8'h00, 8'h80, 8'h00, 8'hbb, 8'h00, 8'h00, 8'h00};
	ocd_dividers dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sync_n_i(sync_n_i), .osc_i(osc_i),
		.ext_clk_i(ext_clk_i), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.pair_a_output_first_o(pa1), .pair_a_output_second_o(pa2), .pair_b_output_first_o(pb1),
		.pair_b_output_second_o(pb2), .duty_correction_enable_o(duty_correction_enable_o));
	always #5 clk_i = ~clk_i;
	task automatic results;
		if (miscompares == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// ready is read at the falling edge so the handshake is judged on settled values
	task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er);
		logic aw, w, b, ah, wh, bh;
		logic [1:0] r;
		@(posedge clk_i);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'h00_0000, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		while (b)
		begin
			@(negedge clk_i);
			ah = aw && s_axi_awready;
			wh = w && s_axi_wready;
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_i);
			if (ah)
			begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (wh)
			begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (bh)
			begin
				b = 1'b0;
				s_axi_bready <= 1'b0;
			end
		end
		chk({30'h0, r}, {30'h0, er});
	endtask : wr
	task automatic rd(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er);
		logic ap, ah, rh;
		logic [31:0] dat;
		logic [1:0] r;
		@(posedge clk_i);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		ap = 1'b1;
		rh = 1'b0;
		while (!rh)
		begin
			@(negedge clk_i);
			ah = ap && s_axi_arready;
			rh = s_axi_rvalid;
			dat = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_i);
			if (ah)
			begin
				ap = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (rh)
				s_axi_rready <= 1'b0;
		end
		chk(dat, {24'h00_0000, v});
		chk({30'h0, r}, {30'h0, er});
	endtask : rd
	// length of one high run and the following low run of a pair output
	task automatic runs(input logic b, output int h, output int l);
		h = 0;
		l = 0;
		@(negedge clk_i);
		while ((b ? pb1 : pa1) !== 1'b0)
			@(negedge clk_i);
		while ((b ? pb1 : pa1) !== 1'b1)
			@(negedge clk_i);
		while ((b ? pb1 : pa1) === 1'b1)
		begin
			h++;
			@(negedge clk_i);
		end
		while ((b ? pb1 : pa1) === 1'b0)
		begin
			l++;
			@(negedge clk_i);
		end
		chk(b ? pb2 : pa2, {31'h0, b ? ~pb1 : ~pa1});
	endtask : runs
	// holds sync for a while, then counts cycles from release to the first change of pair b
	task automatic sync_lat(input logic lvl, output int t);
		@(posedge clk_i);
		sync_n_i <= 1'b0;
		repeat (11) @(posedge clk_i);
		@(negedge clk_i);
		chk(pb1, lvl);
		@(posedge clk_i);
		sync_n_i <= 1'b1;
		t = 0;
		while (pb1 === lvl && t < 100)
		begin
			@(negedge clk_i);
			t++;
		end
	endtask : sync_lat
	initial
	begin
		#800_000;
		miscompares++;
		results();
	end
	initial
	begin
		repeat (20) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		chk(duty_correction_enable_o, 2'b11);
		for (k = 0; k < 7; k++)
			rd(ridx[k], rval[k], RESP_OKAY);
		rd(10'h100, 8'h00, RESP_SLVERR);
		wr(10'h100, 8'h5a, RESP_SLVERR);
		runs(1'b1, hi, lo);
		runs(1'b1, hi, lo);
		chk(hi, 12);
		chk(lo, 12);
		runs(1'b0, hi, lo);
		chk(hi + lo, 2);
		wr(IDX_CTL0, 8'h00, RESP_OKAY);
		wr(IDX_CNT0, 8'h21, RESP_OKAY);
		runs(1'b0, hi, lo);
		runs(1'b0, hi, lo);
		chk(hi, 2);
		chk(lo, 3);
		for (k = 0; k < 6; k++)
		begin
			d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
			wr(IDX_CNT1, d, RESP_OKAY);
			rd(IDX_CNT1, d, RESP_OKAY);
			runs(1'b1, hi, lo);
			runs(1'b1, hi, lo);
			chk(hi, d[3:0] + 1);
			chk(lo, d[7:4] + 1);
			chk(hi + lo, d[3:0] + d[7:4] + 2);
		end
		wr(IDX_CNT1, 8'h33, RESP_OKAY);
		wr(IDX_CTL1, 8'h00, RESP_OKAY);
		sync_lat(1'b0, t0);
		p = 1 + ($random(seed) & 32'h7);
		wr(IDX_CTL1, 8'h10, RESP_OKAY);
		sync_lat(1'b1, t0);
		wr(IDX_CTL1, 8'h10 | 8'(p), RESP_OKAY);
		sync_lat(1'b1, tp);
		chk(tp - t0, p);
		for (k = 0; k < 2; k++)
		begin
			wr(IDX_CTL1, k ? 8'h60 : 8'h40, RESP_OKAY);
			repeat (6) @(posedge clk_i);
			sync_n_i <= 1'b0;
			repeat (4) @(posedge clk_i);
			sync_n_i <= 1'b1;
			repeat (24)
			begin
				@(negedge clk_i);
				chk(pb1, k);
			end
		end
		wr(IDX_CTL0, 8'h40, RESP_OKAY);
		for (k = 0; k < 10; k++)
		begin
			d = 8'($random(seed));
			// first six passes pin the source to 00, 01 and 10 with route off and on
			if (k < 6)
				d[1:0] = 2'(k / 2);
			wr(IDX_SRC, {6'h00, d[1:0]}, RESP_OKAY);
			wr(IDX_RTE0, {6'h00, k[0], 1'b0}, RESP_OKAY);
			@(posedge clk_i);
			osc_i <= d[2];
			ext_clk_i <= d[3];
			repeat (8) @(posedge clk_i);
			@(negedge clk_i);
			chk(pa1, !k[0] || d[0] ? 1'b0 : d[1] ? d[2] : d[3]);
		end
		rd(IDX_STAT, 8'h02, RESP_OKAY);
		wr(IDX_RTE1, 8'h01, RESP_OKAY);
		rd(IDX_RTE1, 8'h01, RESP_OKAY);
		repeat (2) @(posedge clk_i);
		chk(duty_correction_enable_o, 2'b01);
		results();
	end
endmodule : ocd_dividers_tb
`default_nettype wire
